/* File: rtl/cirm_regs.sv */
/*
  Mode register bank: lower-byte calibration invert, per-channel bank and
  segment refresh masks, and the strobe oscillator count readback.
  Assumes mode register writes, reads and the oscillator start/stop commands
  arrive already decoded on the memory clock, and that refresh requests and
  oscillator ticks come from core logic on the reference clock.
*/
// Contract
// - addresses 0x0F, 0x10, 0x11, 0x12 select invert, bank, segment, count-low.
// - an invert bit of one flips the calibration pattern on its lane.
// - bit n drives lower lane n; lanes invert independently.
// - the invert register resets to 0x55.
// - the mask/invert lane always carries the true pattern.
// - no bus inversion during read calibration, even when enabled.
// - a bank mask bit of one skips refresh of that bank.
// - eight write-only bank mask bits, all zero after reset.
// - each channel keeps its own bank mask.
// - a segment mask bit of one stops refresh of that segment; resets zero.
// - segment is the top three row bits, shifted up one in byte mode.
// - each channel keeps its own segment mask.
// - count-low read returns the low eight count bits.
// - a new oscillator start command clears both count bytes.
// - address 0x13 returns the high eight count bits.
`timescale 1ns/1ps
module cirm_regs
  import cirm_pkg::*;
(
  // core clock and reset
  input  wire logic                         REF_CLK_I,
  input  wire logic                         RSTN_I,
  // memory clock
  input  wire logic                         MEM_CK_I,
  // mode register commands (memory clock)
  input  wire logic                         MRW_VALID_I,
  input  wire logic                         MRW_CHAN_I,
  input  wire logic [cirm_pkg::OP_W-1:0]    MRW_OP_I,
  input  wire logic                         MRR_VALID_I,
  input  wire logic [cirm_pkg::MA_W-1:0]    MR_ADDR_I,
  output logic      [cirm_pkg::OP_W-1:0]    MRR_OP_O,
  output logic                              MRR_VALID_O,
  input  wire logic                         MPC_OSC_START_I,
  input  wire logic                         MPC_OSC_STOP_I,
  // read data path (memory clock)
  input  wire logic                         CAL_ACTIVE_I,
  input  wire logic                         CAL_PAT_I,
  input  wire logic                         DBI_EN_I,
  input  wire logic [cirm_pkg::OP_W-1:0]    RD_DQ_I,
  output logic      [cirm_pkg::OP_W-1:0]    DQ_O,
  output logic                              DMI_O,
  // oscillator and refresh (core clock)
  input  wire logic                         OSC_TICK_I,
  input  wire logic                         REF_REQ_I,
  input  wire logic                         REF_CHAN_I,
  input  wire logic [cirm_pkg::BANK_W-1:0]  REF_BANK_I,
  input  wire logic [cirm_pkg::ROW_W-1:0]   REF_ROW_I,
  input  wire logic                         BYTE_MODE_I,
  output logic                              REF_DO_O,
  output logic                              REF_SKIP_O,
  output logic                              OSC_RUN_O
);

  // ==========================================================
  // state
  typedef struct packed {
    cirm_cfg_s        cfg;
    logic             dirty;
    logic [CNT_W-1:0] cnt;
    logic             cmd_pend;
    logic             cmd_start;
    logic [OP_W-1:0]  mrr_op;
    logic             mrr_vld;
    logic [OP_W-1:0]  dq;
    logic             dmi;
  } cirm_link_s;

  typedef struct packed {
    cirm_cfg_s        cfg;
    cirm_osc_e        osc_st;
    logic [CNT_W-1:0] cnt;
    logic             ref_do;
    logic             ref_skip;
  } cirm_core_s;

  cirm_link_s lk_q, lk_d;
  cirm_core_s co_q, co_d;
  logic [SEG_W-1:0] seg_idx;
  logic             ref_masked;

  cirm_cdc_if #(.W(CFG_W)) cfg_if ();
  cirm_cdc_if #(.W(CNT_W)) cnt_if ();
  cirm_cdc_if #(.W(1))     cmd_if ();

  // ones count for read bus inversion
  function automatic logic [3:0] ones8(input logic [OP_W-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < OP_W; i++)
      n = n + {3'h0, v[i]};
    return n;
  endfunction

  // ==========================================================
  // crossings: config to core, count to memory clock, commands to core
  cirm_word_cdc #(.W(CFG_W)) u_cfg_cdc (
    .src_clk_i (MEM_CK_I),
    .dst_clk_i (REF_CLK_I),
    .rst_n_i   (RSTN_I),
    .xfer      (cfg_if)
  );

  cirm_word_cdc #(.W(CNT_W)) u_cnt_cdc (
    .src_clk_i (REF_CLK_I),
    .dst_clk_i (MEM_CK_I),
    .rst_n_i   (RSTN_I),
    .xfer      (cnt_if)
  );

  cirm_word_cdc #(.W(1)) u_cmd_cdc (
    .src_clk_i (MEM_CK_I),
    .dst_clk_i (REF_CLK_I),
    .rst_n_i   (RSTN_I),
    .xfer      (cmd_if)
  );

  // memory-clock side loads; a dirty config waits until the crossing frees
  assign cfg_if.src_data = lk_q.cfg;
  assign cfg_if.src_load = lk_q.dirty;
  assign cmd_if.src_data = lk_q.cmd_start;
  assign cmd_if.src_load = lk_q.cmd_pend;
  // count is resent whenever the crossing is idle, so reads stay fresh
  assign cnt_if.src_data = co_q.cnt;
  assign cnt_if.src_load = 1'b1;

  // ==========================================================
  // memory clock domain
  always_comb
  begin
    lk_d         = lk_q;
    lk_d.mrr_vld = MRR_VALID_I;
    // config handed to the crossing; a same-cycle write sets dirty again
    if (lk_q.dirty && !cfg_if.src_busy)
      lk_d.dirty = 1'b0;
    if (MRW_VALID_I)
    begin
      case (MR_ADDR_I)
        MA_CAL_INV:
        begin
          lk_d.cfg.inv = MRW_OP_I;
          lk_d.dirty   = 1'b1;
        end
        MA_BANK_MSK:
        begin
          lk_d.cfg.bank[MRW_CHAN_I] = MRW_OP_I;
          lk_d.dirty                = 1'b1;
        end
        MA_SEG_MSK:
        begin
          lk_d.cfg.seg[MRW_CHAN_I] = MRW_OP_I;
          lk_d.dirty               = 1'b1;
        end
        default:
        begin
          lk_d.dirty = lk_d.dirty;  // read-only and foreign addresses ignored
        end
      endcase
    end
    // count snapshot; a start command clears it and wins over the update
    if (cnt_if.dst_upd)
      lk_d.cnt = cnt_if.dst_data;
    if (MPC_OSC_START_I)
      lk_d.cnt = CNT_ZERO;
    // one pending oscillator command; a newer one overwrites an unsent one
    if (lk_q.cmd_pend && !cmd_if.src_busy)
      lk_d.cmd_pend = 1'b0;
    if (MPC_OSC_START_I || MPC_OSC_STOP_I)
    begin
      lk_d.cmd_pend  = 1'b1;
      lk_d.cmd_start = MPC_OSC_START_I;
    end
    // mode register read; write-only registers read back as zero
    case (MR_ADDR_I)
      MA_CNT_LOW:  lk_d.mrr_op = lk_q.cnt[OP_W-1:0];
      MA_CNT_HIGH: lk_d.mrr_op = lk_q.cnt[CNT_W-1:OP_W];
      default:     lk_d.mrr_op = RD_NONE;
    endcase
    // read data path: calibration ignores bus inversion entirely
    if (CAL_ACTIVE_I)
    begin
      lk_d.dq  = {OP_W{CAL_PAT_I}} ^ lk_q.cfg.inv;
      lk_d.dmi = CAL_PAT_I;
    end
    else if (DBI_EN_I && (ones8(RD_DQ_I) > DBI_LIMIT))
    begin
      lk_d.dq  = ~RD_DQ_I;
      lk_d.dmi = 1'b1;
    end
    else
    begin
      lk_d.dq  = RD_DQ_I;
      lk_d.dmi = 1'b0;
    end
  end

  // reset leaves invert at its pattern and all masks clear
  always_ff @(posedge MEM_CK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      lk_q     <= '0;
      lk_q.cfg <= CFG_RST;
    end
    else
      lk_q <= lk_d;
  end

  assign MRR_OP_O    = lk_q.mrr_op;
  assign MRR_VALID_O = lk_q.mrr_vld;
  assign DQ_O        = lk_q.dq;
  assign DMI_O       = lk_q.dmi;

  // ==========================================================
  // core clock domain
  assign seg_idx    = BYTE_MODE_I ? REF_ROW_I[SEG_LSB_BYTE +: SEG_W]
                                  : REF_ROW_I[SEG_LSB_NORM +: SEG_W];
  assign ref_masked = co_q.cfg.bank[REF_CHAN_I][REF_BANK_I]
                    | co_q.cfg.seg[REF_CHAN_I][seg_idx];

  always_comb
  begin
    co_d = co_q;
    if (cfg_if.dst_upd)
      co_d.cfg = cfg_if.dst_data;
    // oscillator counts ticks while running and saturates at full scale
    if (co_q.osc_st == OSC_RUN && OSC_TICK_I && co_q.cnt != CNT_MAX)
      co_d.cnt = co_q.cnt + CNT_ONE;
    if (cmd_if.dst_upd)
    begin
      if (cmd_if.dst_data[0])
      begin
        co_d.cnt    = CNT_ZERO;
        co_d.osc_st = OSC_RUN;
      end
      else
      begin
        case (co_q.osc_st)
          OSC_RUN: co_d.osc_st = OSC_DONE;
          default: co_d.osc_st = co_q.osc_st;
        endcase
      end
    end
    // refresh gate: masked banks or segments are skipped
    co_d.ref_do   = REF_REQ_I && !ref_masked;
    co_d.ref_skip = REF_REQ_I && ref_masked;
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      co_q        <= '0;
      co_q.cfg    <= CFG_RST;
      co_q.osc_st <= OSC_IDLE;
    end
    else
      co_q <= co_d;
  end

  assign REF_DO_O   = co_q.ref_do;
  assign REF_SKIP_O = co_q.ref_skip;
  assign OSC_RUN_O  = (co_q.osc_st == OSC_RUN);

  // ==========================================================
  // checks, memory clock
  sequence s_mrw(logic [MA_W-1:0] ma);
    MRW_VALID_I && MR_ADDR_I == ma;
  endsequence

  sequence s_mrr(logic [MA_W-1:0] ma);
    MRR_VALID_I && MR_ADDR_I == ma;
  endsequence

  AST_INV_WRITE: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    s_mrw(MA_CAL_INV) |=> lk_q.cfg.inv == $past(MRW_OP_I))
    else $error("invert register did not take the write");
  AST_BANK_CHAN: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    s_mrw(MA_BANK_MSK) |=> lk_q.cfg.bank[$past(MRW_CHAN_I)] == $past(MRW_OP_I)
      && lk_q.cfg.bank[!$past(MRW_CHAN_I)] == $past(lk_q.cfg.bank[!MRW_CHAN_I]))
    else $error("bank mask write hit the wrong channel");
  AST_RST_VALUES: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    $rose(RSTN_I) |-> lk_q.cfg.inv == CAL_INV_RST && lk_q.cfg.bank == '0
      && lk_q.cfg.seg == '0)
    else $error("mask or invert reset value wrong");
  AST_CAL_LANES: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    CAL_ACTIVE_I |=> DQ_O == ({OP_W{$past(CAL_PAT_I)}} ^ $past(lk_q.cfg.inv)))
    else $error("calibration lane inversion wrong");
  AST_CAL_DMI: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    CAL_ACTIVE_I |=> DMI_O == $past(CAL_PAT_I))
    else $error("mask lane altered during calibration");
  AST_CAL_NO_DBI: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    CAL_ACTIVE_I && DBI_EN_I && !CAL_PAT_I |=> DQ_O == $past(lk_q.cfg.inv) && !DMI_O)
    else $error("bus inversion applied during calibration");
  AST_CNT_LOW: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    s_mrr(MA_CNT_LOW) |=> MRR_VALID_O && MRR_OP_O == $past(lk_q.cnt[OP_W-1:0]))
    else $error("count low byte read wrong");
  AST_CNT_HIGH: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    s_mrr(MA_CNT_HIGH) |=> MRR_VALID_O && MRR_OP_O == $past(lk_q.cnt[CNT_W-1:OP_W]))
    else $error("count high byte read wrong");
  AST_START_CLR: assert property (@(posedge MEM_CK_I) disable iff (!RSTN_I)
    MPC_OSC_START_I |=> lk_q.cnt == CNT_ZERO)
    else $error("start did not clear the count");

  // ==========================================================
  // checks, core clock
  AST_REF_MASK: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    REF_REQ_I |=> REF_SKIP_O == $past(ref_masked) && REF_DO_O == !$past(ref_masked))
    else $error("refresh gate disagrees with masks");
  AST_SEG_FIELD: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    REF_REQ_I && !BYTE_MODE_I && co_q.cfg.seg[REF_CHAN_I][REF_ROW_I[14:12]] |=> REF_SKIP_O)
    else $error("segment taken from the wrong row bits");
  AST_OSC_START: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    cmd_if.dst_upd && cmd_if.dst_data[0] |=> OSC_RUN_O && co_q.cnt == CNT_ZERO)
    else $error("oscillator start did not clear and run");

endmodule // cirm_regs

/* File: include/cirm_pkg.sv */
/*
  Shared constants and types for the calibration-invert, refresh-mask and
  strobe-oscillator mode register bank.
  Assumes a six-bit mode register address and eight-bit operands.
*/
package cirm_pkg;

  // ==========================================================
  // widths
  localparam int MA_W     = 6;
  localparam int OP_W     = 8;
  localparam int CNT_W    = 16;
  localparam int NUM_CHAN = 2;
  localparam int ROW_W    = 16;
  localparam int SEG_W    = 3;
  localparam int BANK_W   = 3;

  // ==========================================================
  // mode register addresses
  localparam logic [MA_W-1:0] MA_CAL_INV  = 6'h0F;
  localparam logic [MA_W-1:0] MA_BANK_MSK = 6'h10;
  localparam logic [MA_W-1:0] MA_SEG_MSK  = 6'h11;
  localparam logic [MA_W-1:0] MA_CNT_LOW  = 6'h12;
  localparam logic [MA_W-1:0] MA_CNT_HIGH = 6'h13;

  // ==========================================================
  // reset values and fixed operands
  localparam logic [OP_W-1:0]  CAL_INV_RST = 8'h55;
  localparam logic [OP_W-1:0]  MASK_RST    = 8'h00;
  localparam logic [OP_W-1:0]  RD_NONE     = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO    = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hFFFF;
  localparam logic [3:0]       DBI_LIMIT   = 4'h4;

  // ==========================================================
  // segment field position in the row address (four gigabits per channel)
  localparam int SEG_LSB_NORM = 12;
  localparam int SEG_LSB_BYTE = 13;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    OSC_IDLE = 2'b00,
    OSC_RUN  = 2'b01,
    OSC_DONE = 2'b11
  } cirm_osc_e;

  typedef struct packed {
    logic [OP_W-1:0]                inv;
    logic [NUM_CHAN-1:0][OP_W-1:0]  bank;
    logic [NUM_CHAN-1:0][OP_W-1:0]  seg;
  } cirm_cfg_s;

  localparam int        CFG_W   = $bits(cirm_cfg_s);
  localparam cirm_cfg_s CFG_RST = '{inv: CAL_INV_RST,
                                    bank: {NUM_CHAN{MASK_RST}},
                                    seg: {NUM_CHAN{MASK_RST}}};

endpackage

/* File: include/cirm_cdc_if.sv */
/*
  Carrier between the register bank and its word crossing helper.
  The user side may hold load high while busy; such loads are ignored.
*/
`timescale 1ns/1ps
interface cirm_cdc_if #(parameter int W = 1);
  logic [W-1:0] src_data;
  logic         src_load;
  logic         src_busy;
  logic [W-1:0] dst_data;
  logic         dst_upd;

  // ==========================================================
  // user side loads words and sees them arrive
  modport user (output src_data, output src_load, input src_busy,
                input dst_data, input dst_upd);
  // ==========================================================
  // crossing side
  modport cdc (input src_data, input src_load, output src_busy,
               output dst_data, output dst_upd);
endinterface

/* File: rtl/cirm_word_cdc.sv */
/*
  Toggle request/acknowledge crossing of one word between two clocks.
  Assumes both clocks share the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module cirm_word_cdc #(
  parameter int W = 1
) (
  // clocks and reset
  input wire logic src_clk_i,
  input wire logic dst_clk_i,
  input wire logic rst_n_i,
  // word transfer
  cirm_cdc_if.cdc  xfer
);

  typedef struct packed {
    logic [W-1:0] data;
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
  } cirm_src_s;

  typedef struct packed {
    logic [W-1:0] data;
    logic         req_s1;
    logic         req_s2;
    logic         ack;
    logic         upd;
  } cirm_dst_s;

  cirm_src_s src_q, src_d;
  cirm_dst_s dst_q, dst_d;

  // ==========================================================
  // source side: data is held stable until the acknowledge returns
  assign xfer.src_busy = src_q.req ^ src_q.ack_s2;

  always_comb
  begin
    src_d        = src_q;
    src_d.ack_s1 = dst_q.ack;
    src_d.ack_s2 = src_q.ack_s1;
    if (xfer.src_load && !xfer.src_busy)
    begin
      src_d.data = xfer.src_data;
      src_d.req  = ~src_q.req;
    end
  end

  always_ff @(posedge src_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      src_q <= '0;
    else
      src_q <= src_d;
  end

  // ==========================================================
  // destination side: a request edge captures the held word once
  assign xfer.dst_data = dst_q.data;
  assign xfer.dst_upd  = dst_q.upd;

  always_comb
  begin
    dst_d        = dst_q;
    dst_d.req_s1 = src_q.req;
    dst_d.req_s2 = dst_q.req_s1;
    dst_d.ack    = dst_q.req_s2;
    dst_d.upd    = dst_q.req_s2 ^ dst_q.ack;
    if (dst_q.req_s2 ^ dst_q.ack)
      dst_d.data = src_q.data;  // source word stable while request is open
  end

  always_ff @(posedge dst_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dst_q <= '0;
    else
      dst_q <= dst_d;
  end

endmodule // cirm_word_cdc

/* File: tb/cirm_ctrl_model.sv */
/*
  Memory controller model: mode register writes, reads and oscillator
  commands, all launched on the memory clock.
  Assumes one request at a time and a read answer one cycle after it.
*/
`timescale 1ns/1ps
module cirm_ctrl_model
  import cirm_pkg::*;
#(
  parameter bit ODD_DENS = 1'b0  // density without the top two segments
) (
  // memory clock
  input  wire logic                      mem_ck_i,
  // requests
  output logic                           mrw_valid_o,
  output logic                           mrw_chan_o,
  output logic      [cirm_pkg::OP_W-1:0] mrw_op_o,
  output logic                           mrr_valid_o,
  output logic      [cirm_pkg::MA_W-1:0] mr_addr_o,
  output logic                           osc_start_o,
  output logic                           osc_stop_o,
  // read answer
  input  wire logic [cirm_pkg::OP_W-1:0] ans_op_i,
  input  wire logic                      ans_valid_i
);
  // ==========================================================
  // idle state at time zero
  initial
  begin
    {mrw_valid_o, mrw_chan_o, mrr_valid_o, osc_start_o, osc_stop_o} = '0;
    mrw_op_o  = '0;
    mr_addr_o = '0;
  end

  // ==========================================================
  // requests; released lines show the inverse so stale values never match
  task automatic mrw(input logic [MA_W-1:0] a, input logic ch, input logic [OP_W-1:0] v);
    @(posedge mem_ck_i);
    mrw_valid_o <= 1'b1;
    mr_addr_o   <= a;
    mrw_chan_o  <= ch;
    mrw_op_o    <= (a == MA_SEG_MSK && ODD_DENS) ? {2'b00, v[5:0]} : v;
    @(posedge mem_ck_i);
    mrw_valid_o <= 1'b0;
    mr_addr_o   <= ~a;
    mrw_chan_o  <= ~ch;
    mrw_op_o    <= ~v;
  endtask

  task automatic mrr(input logic [MA_W-1:0] a, output logic [OP_W-1:0] v, output logic ok);
    @(posedge mem_ck_i);
    mrr_valid_o <= 1'b1;
    mr_addr_o   <= a;
    @(posedge mem_ck_i);
    mrr_valid_o <= 1'b0;
    mr_addr_o   <= ~a;
    #1;
    ok = ans_valid_i;
    v  = ans_op_i;
  endtask

  // both count bytes are needed; high byte lands in the upper half
  task automatic read_count(output logic [CNT_W-1:0] cnt, output logic ok);
    logic [OP_W-1:0] hi;
    logic [OP_W-1:0] lo;
    logic            ok_h;
    logic            ok_l;
    mrr(MA_CNT_HIGH, hi, ok_h);
    mrr(MA_CNT_LOW, lo, ok_l);
    cnt = {hi, lo};
    ok  = ok_h & ok_l;
  endtask

  // a fresh start is how the count gets cleared
  task automatic osc(input logic start);
    @(posedge mem_ck_i);
    osc_start_o <= start;
    osc_stop_o  <= ~start;
    @(posedge mem_ck_i);
    osc_start_o <= 1'b0;
    osc_stop_o  <= 1'b0;
  endtask
endmodule  // cirm_ctrl_model

/* File: tb/tb_top.sv */
/*
  Self-checking bench: invert register, refresh masks, count readback.
  Assumes the controller model and the shared package.
*/
`timescale 1ns/1ps
module tb_top;
  import cirm_pkg::*;

  // ==========================================================
  // signals and expectations
  localparam int TIMEOUT = 20000;
  localparam logic [CNT_W-1:0] TICKS = 16'h012C;
  localparam logic [MA_W-1:0] RD_ADDRS [6] = '{MA_CAL_INV, MA_BANK_MSK, MA_SEG_MSK,
                                               MA_CNT_LOW, MA_CNT_HIGH, 6'h3F};
  logic ref_clk, mem_ck, rstn, mrw_valid, mrw_chan, mrr_valid, osc_start, osc_stop;
  logic cal_active, cal_pat, dbi_en, osc_tick, ref_req, ref_chan, byte_mode, ok;
  logic mrr_vld, dmi, ref_do, ref_skip, osc_run;
  logic [OP_W-1:0]   rd_dq, mrw_op, mrr_op, dq, v, inv_exp;
  logic [MA_W-1:0]   mr_addr;
  logic [BANK_W-1:0] ref_bank;
  logic [ROW_W-1:0]  ref_row;
  logic [CNT_W-1:0]  cnt;
  logic [OP_W-1:0]   bank_exp [NUM_CHAN];
  logic [OP_W-1:0]   seg_exp  [NUM_CHAN];
  int                miscompares, checks, cyc;

  // ==========================================================
  // clocks; the memory clock runs at a third of the core rate, offset so no edges coincide
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    mem_ck = 1'b0;
    #1.3;
    forever #6 mem_ck = ~mem_ck;
  end

  // ==========================================================
  // design and controller
  cirm_regs dut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .MEM_CK_I(mem_ck),
    .MRW_VALID_I(mrw_valid), .MRW_CHAN_I(mrw_chan), .MRW_OP_I(mrw_op),
    .MRR_VALID_I(mrr_valid), .MR_ADDR_I(mr_addr), .MRR_OP_O(mrr_op),
    .MRR_VALID_O(mrr_vld), .MPC_OSC_START_I(osc_start), .MPC_OSC_STOP_I(osc_stop),
    .CAL_ACTIVE_I(cal_active), .CAL_PAT_I(cal_pat), .DBI_EN_I(dbi_en), .RD_DQ_I(rd_dq),
    .DQ_O(dq), .DMI_O(dmi), .OSC_TICK_I(osc_tick), .REF_REQ_I(ref_req),
    .REF_CHAN_I(ref_chan), .REF_BANK_I(ref_bank), .REF_ROW_I(ref_row),
    .BYTE_MODE_I(byte_mode), .REF_DO_O(ref_do), .REF_SKIP_O(ref_skip),
    .OSC_RUN_O(osc_run));
  cirm_ctrl_model ctrl (.mem_ck_i(mem_ck), .mrw_valid_o(mrw_valid), .mrw_chan_o(mrw_chan),
    .mrw_op_o(mrw_op), .mrr_valid_o(mrr_valid), .mr_addr_o(mr_addr),
    .osc_start_o(osc_start), .osc_stop_o(osc_stop), .ans_op_i(mrr_op),
    .ans_valid_i(mrr_vld));

  // ==========================================================
  // compares and reporting
  task automatic chk_byte(input logic [OP_W-1:0] g, input logic [OP_W-1:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    chk_byte({7'h00, g}, {7'h00, e}, m);
  endtask
  task automatic summarize();
    $display("checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut short here
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == TIMEOUT)
    begin
      miscompares++;
      summarize();
    end
  end

  // ==========================================================
  // operations; expectations come from the register rules only
  task automatic wr(input logic [MA_W-1:0] a, input logic ch, input logic [OP_W-1:0] d);
    ctrl.mrw(a, ch, d);
    case (a)
      MA_CAL_INV:  inv_exp = d;
      MA_BANK_MSK: bank_exp[ch] = d;
      MA_SEG_MSK:  seg_exp[ch] = d;
      default:     ;
    endcase
  endtask
  task automatic cal_beat(input logic p);
    @(posedge mem_ck);
    cal_active <= 1'b1;
    cal_pat    <= p;
    dbi_en     <= 1'b1;
    rd_dq      <= 8'($urandom);
    @(posedge mem_ck);
    cal_active <= 1'b0;
    #1;
    chk_byte(dq, {OP_W{p}} ^ inv_exp, "calibration lanes");
    chk_bit(dmi, p, "calibration mask lane");
  endtask
  task automatic rd_beat(input logic [OP_W-1:0] d, input logic en);
    logic flip;
    flip = en && ($countones(d) > DBI_LIMIT);
    @(posedge mem_ck);
    rd_dq  <= d;
    dbi_en <= en;
    @(posedge mem_ck);
    #1;
    chk_byte(dq, flip ? ~d : d, "read lanes");
    chk_bit(dmi, flip, "read mask lane");
  endtask
  task automatic ref_chk(input logic ch, input logic [BANK_W-1:0] b,
                         input logic [ROW_W-1:0] r, input logic bm);
    logic [SEG_W-1:0] s;
    logic             sk;
    s  = bm ? r[15:13] : r[14:12];
    sk = bank_exp[ch][b] | seg_exp[ch][s];
    @(posedge ref_clk);
    {ref_req, ref_chan, ref_bank, ref_row, byte_mode} <= {1'b1, ch, b, r, bm};
    @(posedge ref_clk);
    ref_req <= 1'b0;
    #1;
    chk_bit(ref_skip, sk, "refresh skipped");
    chk_bit(ref_do, ~sk, "refresh done");
  endtask
  task automatic wait_run(input logic e);
    for (int i = 0; i < 40 && osc_run !== e; i++)
    begin
      @(posedge ref_clk);
      #1;
    end
    chk_bit(osc_run, e, "oscillator running");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rstn = 1'b0;
    {cal_active, cal_pat, dbi_en, osc_tick, ref_req, ref_chan, byte_mode} = '0;
    {rd_dq, ref_bank, ref_row} = '0;
    {miscompares, checks, cyc} = '0;
    inv_exp  = CAL_INV_RST;
    bank_exp = '{default: MASK_RST};
    seg_exp  = '{default: MASK_RST};
    void'($urandom(14655));
    repeat (4) @(posedge mem_ck);
    @(posedge ref_clk);
    rstn <= 1'b1;
    // write-only places, the cleared count and an unmapped address all read zero
    foreach (RD_ADDRS[i])
    begin
      ctrl.mrr(RD_ADDRS[i], v, ok);
      chk_bit(ok, 1'b1, "read answer");
      chk_byte(v, RD_NONE, "reset read");
    end
    cal_beat(1'b1);
    cal_beat(1'b0);
    repeat (4) ref_chk(1'($urandom), 3'($urandom), 16'($urandom), 1'($urandom));
    $display("test reset done");
    // invert values: both extremes, then random
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      wr(MA_CAL_INV, 1'($urandom), v);
      cal_beat(1'b0);
      cal_beat(1'b1);
    end
    rd_beat(8'hF8, 1'b1);
    rd_beat(8'hF0, 1'b1);
    rd_beat(8'hF8, 1'b0);
    $display("test invert done");
    // masks differ per channel; the first round is hand-picked
    for (int it = 0; it < 4; it++)
    begin
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        wr(MA_BANK_MSK, c[0], it == 0 ? (c == 0 ? 8'h00 : 8'hFF) : 8'($urandom));
        wr(MA_SEG_MSK, c[0], it == 0 ? (c == 0 ? 8'h80 : 8'h00) : 8'($urandom));
      end
      repeat (20) @(posedge ref_clk);
      repeat (16) ref_chk(1'($urandom), 3'($urandom), 16'($urandom), 1'($urandom));
    end
    $display("test refresh done");
    // count a known number of ticks, then clear it with a fresh start
    ctrl.osc(1'b1);
    wait_run(1'b1);
    repeat (int'(TICKS)) @(posedge ref_clk) osc_tick <= 1'b1;
    @(posedge ref_clk) osc_tick <= 1'b0;
    ctrl.osc(1'b0);
    wait_run(1'b0);
    wr(MA_CNT_LOW, 1'b0, 8'hA5);
    repeat (30) @(posedge mem_ck);
    ctrl.read_count(cnt, ok);
    chk_bit(ok, 1'b1, "count answer");
    chk_byte(cnt[15:8], TICKS[15:8], "count high");
    chk_byte(cnt[7:0], TICKS[7:0], "count low");
    ctrl.osc(1'b1);
    repeat (30) @(posedge mem_ck);
    ctrl.read_count(cnt, ok);
    chk_byte(cnt[15:8], 8'h00, "cleared high");
    chk_byte(cnt[7:0], 8'h00, "cleared low");
    ctrl.osc(1'b0);
    $display("test oscillator done");
    summarize();
  end
endmodule  // tb_top
